// ===== src/opst_top.sv
// Operation status register group and measurement trigger state logic.
// Assumes a command decoder on clk presenting one-cycle strobes and values
// already converted from decimal weight sums to binary words.
//
// Summary of operation
// - Condition register mirrors live state; reading it changes nothing.
// - Fixed transition filter latches each detected change as sticky event bit.
// - Event AND enable, any set bit raises operation summary bit.
// - Event query returns contents then clears every event bit.
// - Clear-status command clears event register.
// - Power-up clears event and enable registers.
// - Enable register read/write; after power-up only a write of zero clears it.
// - Host values are weight sums, handled as plain binary words here.
// - Bits 15..11, 6 and 0 read zero in condition and event.
// - Bit 7 high during correction; event on correction completion.
// - Bit 5 high while awaiting trigger; event on entering wait.
// - Bit 4 follows end-of-measurement pin; event on measurement done.
// - Bit 3 follows acquisition pin; event on acquisition done.
// - Bit 2 high while ranging; event when range established.
// - Bit 1 high during trigger delay; event when delay elapsed.
// - Continuous off: stay idle after one measurement, ignore triggers.
// - Initiate moves idle to trigger-waiting.
// - Device reset clears continuous mode; power-up sets it.
// - External source: handler trigger acts like bus trigger.
// - Bus source: device trigger starts one measurement, returns result.
// - Result order is status, primary value, secondary value.
// - Blocking read defers later commands until result fully stored.
// - Operation summary drives status byte bit 7.
module opst_top (
   input  wire logic                   clk,                  // 200 MHz clock
   input  wire logic                   rst,                  // Power-on reset
   input  wire logic                   cmd_dev_reset,        // Device reset pulse
   input  wire logic                   cmd_clear_status,     // Clear-status pulse
   input  wire logic                   cmd_cond_read,        // Condition query
   input  wire logic                   cmd_event_read,       // Event query
   input  wire logic                   cmd_enable_write,     // Enable write
   input  wire logic                   cmd_enable_read,      // Enable query
   input  wire logic [15:0]            cmd_wdata,            // Write value
   input  wire logic                   cmd_init,             // Initiate
   input  wire logic                   cmd_abort,            // Abort to idle
   input  wire logic                   cmd_cont_write,       // Set continuous
   input  wire logic                   cmd_cont_value,       // Continuous value
   input  wire logic                   cmd_src_write,        // Set trigger source
   input  wire opst_pkg::opst_src_t    cmd_src_value,        // Trigger source
   input  wire logic                   cmd_bus_trigger,      // Trigger command
   input  wire logic                   cmd_dev_trigger,      // Device-trigger
   input  wire logic                   cmd_read_query,       // Blocking read
   input  wire logic                   cmd_valid,            // Next command offered
   output logic                        cmd_ready,            // Command accepted
   output logic [15:0]                 rd_data,              // Query answer
   output logic                        rd_valid,             // Answer strobe
   input  wire logic                   handler_trigger,      // Handler trigger pin
   input  wire logic                   handler_end_of_measurement, // Measuring pin
   input  wire logic                   handler_acquiring,    // Acquisition pin
   input  wire logic                   correction_active,    // Correction running
   input  wire logic                   correction_done,      // Correction done
   input  wire logic                   ranging_active,       // Range switching
   input  wire logic                   range_done,           // Range established
   input  wire logic                   settling_active,      // Trigger delay running
   input  wire logic                   settle_done,          // Delay elapsed
   input  wire logic                   result_buffer_one_full_full,            // Result buffer one full
   input  wire logic                   result_buffer_two_full_full,            // Result buffer two full
   input  wire logic                   result_buffer_three_full_full,            // Result buffer three full
   output logic                        measuring_flag_start,           // Start measurement
   input  wire logic                   measuring_flag_done,            // Measurement done
   input  wire logic [31:0]            measuring_flag_status,          // Measurement status
   input  wire logic [31:0]            measuring_flag_primary,         // Primary value
   input  wire logic [31:0]            measuring_flag_secondary,       // Secondary value
   output logic [31:0]                 res_data,             // Result word
   output logic                        res_valid,            // Result word strobe
   output logic                        res_last,             // Last result word
   output logic                        operation_summary_bit // Status byte bit 7
);
   ////////////////////////////////////////////////////////////////////////////
   logic              trig_s;
   logic              eom_s;
   logic              acq_s;
   logic              trig_s_q;
   logic              eom_s_q;
   logic              acq_s_q;
   logic [15:0]       cond;
   logic [15:0]       done;
   logic [15:0]       hit;
   logic [15:0]       event_q;
   logic [15:0]       event_d;
   logic [15:0]       enable_q;
   logic              cont_q;
   logic              blocking_q;
   logic              reply_q;
   logic [1:0]        word_q;
   logic [31:0]       res_q;
   logic              res_valid_q;
   logic              res_last_q;
   logic [15:0]       rd_q;
   logic              rd_valid_q;
   logic              ext_edge;
   logic              trigger;
   logic              enter_wait;
   logic              measuring_flag_done_q;
   opst_pkg::opst_src_t  src_q;
   opst_pkg::opst_state_t state_q;
   opst_pkg::opst_state_t state_d;

   opst_sync u_sync_trig (.clk(clk), .rst(rst), .d(handler_trigger), .q(trig_s));
   opst_sync u_sync_eom  (.clk(clk), .rst(rst), .d(handler_end_of_measurement), .q(eom_s));
   opst_sync u_sync_acq  (.clk(clk), .rst(rst), .d(handler_acquiring), .q(acq_s));

   always_ff @(posedge clk) begin
      if (rst) begin
         trig_s_q    <= 1'b0;
         eom_s_q     <= 1'b0;
         acq_s_q     <= 1'b0;
         measuring_flag_done_q <= 1'b0;
      end else begin
         trig_s_q    <= trig_s;
         eom_s_q     <= eom_s;
         acq_s_q     <= acq_s;
         measuring_flag_done_q <= measuring_flag_done;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Condition assembly
   // unused bits forced zero
   assign cond[15:11] = 5'h00;
   assign cond[6]     = 1'b0;
   assign cond[0]     = 1'b0;
   assign cond[opst_pkg::BIT_RESULT_BUFFER_THREE_FULL] = result_buffer_three_full_full;
   assign cond[opst_pkg::BIT_RESULT_BUFFER_TWO_FULL] = result_buffer_two_full_full;
   assign cond[opst_pkg::BIT_RESULT_BUFFER_ONE_FULL] = result_buffer_one_full_full;
   assign cond[opst_pkg::BIT_CORRECTION_IN_PROGRESS] = correction_active;
   assign cond[opst_pkg::BIT_WAIT] = (state_q == opst_pkg::OPST_WAIT_TRIG);
   assign cond[opst_pkg::BIT_MEASURING_FLAG] = eom_s;
   assign cond[opst_pkg::BIT_ACQ]  = acq_s;
   assign cond[opst_pkg::BIT_RANGING_FLAG] = ranging_active;
   assign cond[opst_pkg::BIT_SETTLING_FLAG] = settling_active;

   // Completion pulses; waiting bit is caught by the rising edge alone
   assign done[15:11] = 5'h00;
   assign done[10:8]  = 3'h0;
   assign done[opst_pkg::BIT_CORRECTION_IN_PROGRESS] = correction_done;
   assign done[6]     = 1'b0;
   assign done[opst_pkg::BIT_WAIT] = 1'b0;
   assign done[opst_pkg::BIT_MEASURING_FLAG] = eom_s_q & ~eom_s;
   assign done[opst_pkg::BIT_ACQ]  = acq_s_q & ~acq_s;
   assign done[opst_pkg::BIT_RANGING_FLAG] = range_done;
   assign done[opst_pkg::BIT_SETTLING_FLAG] = settle_done;
   assign done[0]     = 1'b0;

   opst_edge u_edge (.clk(clk), .rst(rst), .cond(cond), .done(done), .hit(hit));

   ////////////////////////////////////////////////////////////////////////////
   // Event and enable registers
   // query and clear-status clear; new hits win over the clear
   assign event_d = ((cmd_event_read | cmd_clear_status) ? opst_pkg::OP_REG_RESET : event_q)
                    | hit;

   always_ff @(posedge clk) begin
      if (rst) begin
         event_q  <= opst_pkg::OP_REG_RESET;
         enable_q <= opst_pkg::OP_REG_RESET;
      end else begin
         event_q <= event_d & opst_pkg::OP_VALID_MASK;
         if (cmd_enable_write) begin
            enable_q <= cmd_wdata;
         end
      end
   end

   assign operation_summary_bit = |(event_q & enable_q);

   // read returns live condition without side effect
   // answers are the binary weight sum
   always_ff @(posedge clk) begin
      if (rst) begin
         rd_q       <= opst_pkg::OP_REG_RESET;
         rd_valid_q <= 1'b0;
      end else begin
         rd_valid_q <= cmd_cond_read | cmd_event_read | cmd_enable_read;
         if (cmd_cond_read) begin
            rd_q <= cond;
         end else if (cmd_event_read) begin
            rd_q <= event_q;
         end else if (cmd_enable_read) begin
            rd_q <= enable_q;
         end
      end
   end

   assign rd_data  = rd_q;
   assign rd_valid = rd_valid_q;

   ////////////////////////////////////////////////////////////////////////////
   // Trigger state machine
   assign ext_edge = trig_s & ~trig_s_q;
   // device-trigger counts only on bus source
   assign trigger  = (src_q == opst_pkg::OPST_SRC_IMM) |
                     ((src_q == opst_pkg::OPST_SRC_BUS) & (cmd_bus_trigger | cmd_dev_trigger)) |
                     ((src_q == opst_pkg::OPST_SRC_EXT) & (ext_edge | cmd_bus_trigger));

   always_comb begin
      state_d = state_q;
      case (state_q)
         opst_pkg::OPST_IDLE: begin
            if (cmd_init | cont_q | cmd_read_query) begin
               state_d = opst_pkg::OPST_WAIT_TRIG;
            end
         end
         opst_pkg::OPST_WAIT_TRIG: begin
            if (trigger) begin
               state_d = opst_pkg::OPST_MEASURE;
            end
         end
         opst_pkg::OPST_MEASURE: begin
            if (measuring_flag_done) begin
               state_d = opst_pkg::OPST_DONE;
            end
         end
         opst_pkg::OPST_DONE: begin
            state_d = cont_q ? opst_pkg::OPST_WAIT_TRIG : opst_pkg::OPST_IDLE;
         end
         default: begin
            state_d = opst_pkg::OPST_IDLE;
         end
      endcase
      if (cmd_abort) begin
         state_d = opst_pkg::OPST_IDLE;
      end
   end

   assign enter_wait = (state_d == opst_pkg::OPST_WAIT_TRIG) &
                       (state_q != opst_pkg::OPST_WAIT_TRIG);
   assign measuring_flag_start = (state_q == opst_pkg::OPST_WAIT_TRIG) & trigger & ~cmd_abort;

   always_ff @(posedge clk) begin
      if (rst) begin
         state_q <= opst_pkg::OPST_IDLE;
         cont_q  <= opst_pkg::CONT_POWERUP;
         src_q   <= opst_pkg::OPST_SRC_IMM;
      end else begin
         state_q <= state_d;
         if (cmd_dev_reset) begin
            cont_q  <= opst_pkg::CONT_DEV_RESET;
            src_q   <= opst_pkg::OPST_SRC_IMM;
            state_q <= opst_pkg::OPST_IDLE;
         end else begin
            if (cmd_cont_write) begin
               cont_q <= cmd_cont_value;
            end
            if (cmd_src_write) begin
               src_q <= cmd_src_value;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Result return and blocking read
   always_ff @(posedge clk) begin
      if (rst) begin
         blocking_q  <= 1'b0;
         reply_q     <= 1'b0;
         word_q      <= 2'h0;
         res_q       <= 32'h0000_0000;
         res_valid_q <= 1'b0;
         res_last_q  <= 1'b0;
      end else begin
         res_valid_q <= 1'b0;
         res_last_q  <= 1'b0;
         if (cmd_read_query) begin
            blocking_q <= 1'b1;
         end
         if (measuring_flag_start & (cmd_dev_trigger | blocking_q | cmd_read_query)) begin
            reply_q <= 1'b1;
         end
         if (reply_q & measuring_flag_done_q & (word_q == 2'h0)) begin
            word_q <= 2'h1;
         end
         if (word_q != 2'h0) begin
            res_valid_q <= 1'b1;
            if (word_q == 2'(opst_pkg::RW_STATUS + 1)) begin
               res_q  <= measuring_flag_status;
               word_q <= 2'h2;
            end else if (word_q == 2'(opst_pkg::RW_PRIMARY + 1)) begin
               res_q  <= measuring_flag_primary;
               word_q <= 2'h3;
            end else begin
               res_q      <= measuring_flag_secondary;
               res_last_q <= 1'b1;
               word_q     <= 2'h0;
               reply_q    <= 1'b0;
               blocking_q <= 1'b0;
            end
         end
      end
   end

   assign res_data  = res_q;
   assign res_valid = res_valid_q;
   assign res_last  = res_last_q;
   assign cmd_ready = ~blocking_q;

   ////////////////////////////////////////////////////////////////////////////
   a_sum_tracks: assert property (@(posedge clk) disable iff (rst)
      (|(hit & enable_q)) && !cmd_enable_write |=> operation_summary_bit)
      else $error("summary bit mismatch");
   a_unused_zero: assert property (@(posedge clk) disable iff (rst)
      ((event_q | cond) & ~opst_pkg::OP_VALID_MASK) == 16'h0000)
      else $error("unused bit set");
   a_event_clear: assert property (@(posedge clk) disable iff (rst)
      cmd_event_read |=> (event_q == ($past(hit) & opst_pkg::OP_VALID_MASK)))
      else $error("event not cleared by query");
   a_event_sticky: assert property (@(posedge clk) disable iff (rst)
      (hit != 16'h0000) |=> ((event_q & $past(hit)) == $past(hit)))
      else $error("event hit lost");
   a_enable_keep: assert property (@(posedge clk) disable iff (rst)
      (!cmd_enable_write && !cmd_dev_reset) |=> $stable(enable_q))
      else $error("enable changed without write");
   a_wait_event: assert property (@(posedge clk) disable iff (rst)
      enter_wait && !cmd_dev_reset |=> ##1 event_q[opst_pkg::BIT_WAIT])
      else $error("wait event missing");
   a_init_arm: assert property (@(posedge clk) disable iff (rst)
      (state_q == opst_pkg::OPST_IDLE) && cmd_init && !cmd_abort && !cmd_dev_reset
      |=> state_q == opst_pkg::OPST_WAIT_TRIG)
      else $error("initiate did not arm");
   a_block_hold: assert property (@(posedge clk) disable iff (rst)
      cmd_read_query |=> !cmd_ready)
      else $error("blocking read not holding");
   sequence s_three_words;
      res_valid ##1 res_valid ##1 (res_valid && res_last);
   endsequence
   a_result_order: assert property (@(posedge clk) disable iff (rst)
      (word_q == 2'h1) |=> s_three_words)
      else $error("result words broken");
endmodule

// ===== src/opst_pkg.sv
// Constants for the operation status group and trigger state logic.
// Assumes a command decoder upstream that delivers one-cycle command strobes.
package opst_pkg;
   localparam int          REG_W            = 16;
   localparam int          SB_W             = 8;
   localparam logic [15:0] OP_REG_RESET     = 16'h0000;
   localparam logic [15:0] OP_VALID_MASK    = 16'h07BE;
   localparam int          BIT_RESULT_BUFFER_THREE_FULL         = 10;
   localparam int          BIT_RESULT_BUFFER_TWO_FULL         = 9;
   localparam int          BIT_RESULT_BUFFER_ONE_FULL         = 8;
   localparam int          BIT_CORRECTION_IN_PROGRESS         = 7;
   localparam int          BIT_WAIT         = 5;
   localparam int          BIT_MEASURING_FLAG         = 4;
   localparam int          BIT_ACQ          = 3;
   localparam int          BIT_RANGING_FLAG         = 2;
   localparam int          BIT_SETTLING_FLAG         = 1;
   localparam int          SB_OPER_BIT      = 7;
   localparam logic        CONT_POWERUP     = 1'b1;
   localparam logic        CONT_DEV_RESET   = 1'b0;
   localparam int          RESULT_WORDS     = 3;
   localparam int          RW_STATUS        = 0;
   localparam int          RW_PRIMARY       = 1;
   localparam int          RW_SECONDARY     = 2;
   localparam int          RES_W            = 32;

   typedef enum logic [1:0] {
      OPST_SRC_IMM,
      OPST_SRC_BUS,
      OPST_SRC_EXT
   } opst_src_t;

   typedef enum logic [1:0] {
      OPST_IDLE,
      OPST_WAIT_TRIG,
      OPST_MEASURE,
      OPST_DONE
   } opst_state_t;
endpackage

// ===== src/opst_edge.sv
// Rising-edge or completion-pulse detector for the event bits.
// Assumes both inputs are on clk.
module opst_edge (
   input  wire logic        clk,     // System clock
   input  wire logic        rst,     // Synchronous reset
   input  wire logic [15:0] cond,    // Condition bits
   input  wire logic [15:0] done,    // Completion pulses
   output logic      [15:0] hit      // Detected transitions
);
   logic [15:0] cond_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         cond_q <= opst_pkg::OP_REG_RESET;
      end else begin
         cond_q <= cond;
      end
   end

   assign hit = ((cond & ~cond_q) | done) & opst_pkg::OP_VALID_MASK;
endmodule

// ===== src/opst_sync.sv
// Two-flop synchroniser for a pin level.
// Assumes the pin is asynchronous to clk.
module opst_sync (
   input  wire logic clk,     // System clock
   input  wire logic rst,     // Synchronous reset
   input  wire logic d,       // Asynchronous level
   output logic      q        // Synchronised level
);
   logic s1_q;
   logic s2_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
      end else begin
         s1_q <= d;
         s2_q <= s1_q;
      end
   end

   assign q = s2_q;
endmodule

// ===== dv/opst_host.sv
// Host model: issues one-cycle command strobes and collects query answers.
// Assumes opst_top command strobes are wired from stb in the bench's order.
module opst_host (
   input  wire logic          clk,       // System clock
   input  wire logic          cmd_ready, // Command accepted
   input  wire logic [15:0]   rd_data,   // Query answer
   input  wire logic          rd_valid,  // Answer strobe
   output logic      [12:0]   stb,       // Command strobes
   output logic      [15:0]   wdata,     // Enable value
   output logic               cont_v,    // Continuous value
   output opst_pkg::opst_src_t src_v    // Trigger source
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      stb = 13'h0000;
      wdata = 16'h0000;
      cont_v = 1'b0;
      src_v = opst_pkg::OPST_SRC_IMM;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // hold off while blocked
   // Bounded so a stuck ready shows up as a wrong answer, not a hang
   task automatic send(input int idx);
      int n;
      n = 0;
      @(posedge clk);
      #1;
      while (cmd_ready !== 1'b1 && n < 400) begin
         @(posedge clk);
         #1;
         n++;
      end
      stb[idx] = 1'b1;
      @(posedge clk);
      #1 stb[idx] = 1'b0;
   endtask

   // answer read as binary weight sum
   task automatic ask(input int idx, output logic [15:0] got);
      send(idx);
      got = (rd_valid === 1'b1) ? rd_data : 16'hXXXX;
   endtask
endmodule

// ===== dv/opst_top_test.sv
// Self-checking bench for the operation status group and trigger logic.
// Assumes opst_host drives commands; the bench plays the measurement side.
module opst_top_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic                clk = 1'b0;
   logic                rst = 1'b1;
   logic [12:0]         stb;
   logic [15:0]         wdata, rd_data, got;
   logic                cont_v, cmd_ready, rd_valid, measuring_flag_start;
   logic                res_valid, res_last, opsum;
   opst_pkg::opst_src_t src_v;
   logic [8:0]          lv;
   logic [3:0]          dn;
   logic [31:0]         res_data;
   logic [31:0]         mv [3];
   logic [31:0]         words [$];
   logic                last_rdy = 1'b1;
   int                  errors = 0, check_count = 0, starts = 0, s0;

   always #2.5 clk = ~clk;

   opst_host u_host (.clk(clk), .cmd_ready(cmd_ready), .rd_data(rd_data),
      .rd_valid(rd_valid), .stb(stb), .wdata(wdata), .cont_v(cont_v), .src_v(src_v));

   opst_top u_dut (.clk(clk), .rst(rst), .cmd_dev_reset(stb[0]),
      .cmd_clear_status(stb[1]), .cmd_cond_read(stb[2]), .cmd_event_read(stb[3]),
      .cmd_enable_write(stb[4]), .cmd_enable_read(stb[5]), .cmd_wdata(wdata),
      .cmd_init(stb[6]), .cmd_abort(stb[7]), .cmd_cont_write(stb[8]),
      .cmd_cont_value(cont_v), .cmd_src_write(stb[9]), .cmd_src_value(src_v),
      .cmd_bus_trigger(stb[10]), .cmd_dev_trigger(stb[11]), .cmd_read_query(stb[12]),
      .cmd_valid(1'b1), .cmd_ready(cmd_ready), .rd_data(rd_data), .rd_valid(rd_valid),
      .handler_trigger(lv[8]), .handler_end_of_measurement(lv[6]),
      .handler_acquiring(lv[7]), .correction_active(lv[0]), .correction_done(dn[0]),
      .ranging_active(lv[1]), .range_done(dn[1]), .settling_active(lv[2]),
      .settle_done(dn[2]), .result_buffer_one_full_full(lv[3]), .result_buffer_two_full_full(lv[4]), .result_buffer_three_full_full(lv[5]),
      .measuring_flag_start(measuring_flag_start), .measuring_flag_done(dn[3]), .measuring_flag_status(mv[0]),
      .measuring_flag_primary(mv[1]), .measuring_flag_secondary(mv[2]), .res_data(res_data),
      .res_valid(res_valid), .res_last(res_last), .operation_summary_bit(opsum));

   ////////////////////////////////////////////////////////////////////////////////
   // Monitor reads pre-edge values, so registered strobes are seen once
   // Ready is caught while result words are still being stored
   always @(posedge clk) begin
      if (measuring_flag_start === 1'b1) starts++;
      if (res_valid === 1'b1) words.push_back(res_data);
      if (res_valid === 1'b1 && res_last !== 1'b1) last_rdy = cmd_ready;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask

   task automatic q(input int idx, input logic [15:0] exp);
      u_host.ask(idx, got);
      check({16'h0000, got}, {16'h0000, exp});
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic pulse(input int i);
      @(posedge clk);
      #1 dn[i] = 1'b1;
      @(posedge clk);
      #1 dn[i] = 1'b0;
   endtask

   task automatic tally_and_finish();
      $display("checks %0d, mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #20000;
      errors++;
      $display("unexpected at %0t: watchdog expired", $time);
      tally_and_finish();
   end

   initial begin
      lv = 9'h000;
      dn = 4'h0;
      mv = '{32'h0000_0011, 32'h0000_2222, 32'h0003_3333};
      repeat (8) @(posedge clk);
      #1 rst = 1'b0;
      cyc(3);
      check(32'(starts != 0), 32'h0000_0001);
      q(5, 16'h0000);
      u_host.send(0);
      u_host.send(1);
      q(3, 16'h0000);
      $display("test reset done");
      // Every live level high; unused bits must still read zero
      lv[7:0] = 8'hFF;
      cyc(4);
      q(2, 16'h079E);
      q(2, 16'h079E);
      u_host.send(1);
      lv[7:0] = 8'h00;
      cyc(4);
      q(3, 16'h0018);
      pulse(0);
      pulse(1);
      pulse(2);
      q(3, 16'h0086);
      q(3, 16'h0000);
      $display("test events done");
      wdata = 16'h0080;
      u_host.send(4);
      q(5, 16'h0080);
      pulse(0);
      cyc(1);
      check({31'h0, opsum}, 32'h1);
      u_host.send(1);
      check({31'h0, opsum}, 32'h0);
      u_host.send(0);
      q(5, 16'h0080);
      wdata = 16'h0000;
      u_host.send(4);
      q(5, 16'h0000);
      $display("test enable done");
      src_v = opst_pkg::OPST_SRC_BUS;
      u_host.send(9);
      u_host.send(1);
      u_host.send(6);
      q(2, 16'h0020);
      q(3, 16'h0020);
      s0 = starts;
      u_host.send(11);
      cyc(1);
      check(32'(starts - s0), 32'h1);
      words.delete();
      pulse(3);
      cyc(6);
      check(32'(words.size()), 32'h3);
      for (int i = 0; i < 3; i++) check(words[i], mv[i]);
      q(2, 16'h0000);
      s0 = starts;
      u_host.send(10);
      cyc(2);
      check(32'(starts - s0), 32'h0);
      $display("test bus trigger done");
      src_v = opst_pkg::OPST_SRC_EXT;
      u_host.send(9);
      u_host.send(6);
      s0 = starts;
      lv[8] = 1'b1;
      cyc(5);
      check(32'(starts - s0), 32'h1);
      pulse(3);
      lv[8] = 1'b0;
      cyc(3);
      words.delete();
      mv = '{32'h0000_0044, 32'h0000_5555, 32'h0006_6666};
      u_host.send(12);
      check({31'h0, cmd_ready}, 32'h0);
      lv[8] = 1'b1;
      cyc(5);
      pulse(3);
      cyc(6);
      check({31'h0, last_rdy}, 32'h0);
      check({31'h0, cmd_ready}, 32'h1);
      check(32'(words.size()), 32'h3);
      for (int i = 0; i < 3; i++) check(words[i], mv[i]);
      $display("test handler trigger done");
      // Continuous mode re-arms; abort then single shot stays idle
      cont_v = 1'b1;
      u_host.send(8);
      q(2, 16'h0020);
      s0 = starts;
      u_host.send(10);
      pulse(3);
      q(2, 16'h0020);
      check(32'(starts - s0), 32'h1);
      cont_v = 1'b0;
      u_host.send(8);
      u_host.send(7);
      s0 = starts;
      u_host.send(10);
      q(2, 16'h0000);
      check(32'(starts - s0), 32'h0);
      $display("test continuous done");
      tally_and_finish();
   end
endmodule
